//--- hdl/plc_core.sv
// Register and control logic of a loop clock generator.
// Assumes a synchronous Avalon-MM master, lock and mode inputs synchronous to clk.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module plc_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic lock_in,
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic break_state,
  input wire logic break_clear_enable,
  input wire logic oscillator_stop_enable,
  output logic loop_enable,
  output logic vco_select,
  output logic clock_hold,
  output logic osc_enable,
  output logic outputs_low,
  output logic clockgen_interrupt_output,
  output logic [11:0] mult_eff,
  output logic [7:0] vco_range_eff,
  output logic [3:0] ref_div_eff
);
  logic irq_en_reg;
  logic irq_flag_reg;
  logic pwr_on_reg;
  logic bcs_reg;
  logic auto_reg;
  logic lock_q_reg;
  logic [11:0] mul_reg;
  logic [7:0] range_reg;
  logic [3:0] div_reg;
  logic [2:0] hold_cnt_reg;
  logic ack_reg;
  plc_pkg::plc_mode_t mode_reg;
  logic access;
  logic wr_lane;
  logic wr_ctrl;
  logic wr_bw;
  logic wr_mul_hi;
  logic wr_mul_lo;
  logic wr_range;
  logic wr_div;
  logic rd_any;
  logic rd_ctrl;
  logic prog_open;
  logic range_zero;
  logic pwr_clear_ok;
  logic bcs_set_ok;
  logic lock_change;
  logic lock_vis;
  logic stopping;
  logic stop_dark;
  logic hold_idle;
  logic hold_last;
  logic [31:0] read_mux;

  // One wait state: request is taken when ack_reg rises
  assign access = (avs_read | avs_write) & ~ack_reg;
  // Only byte lane 0 carries register bits; other lanes alone write nothing
  assign wr_lane = access & avs_write & avs_byteenable[0];
  assign wr_ctrl = wr_lane & (avs_address == plc_pkg::ADDR_CTRL);
  assign wr_bw = wr_lane & (avs_address == plc_pkg::ADDR_BW);
  // programming writes need the loop off
  assign prog_open = ~pwr_on_reg;
  assign wr_mul_hi = wr_lane & prog_open & (avs_address == plc_pkg::ADDR_MUL_HI);
  assign wr_mul_lo = wr_lane & prog_open & (avs_address == plc_pkg::ADDR_MUL_LO);
  assign wr_range = wr_lane & prog_open & (avs_address == plc_pkg::ADDR_VCO_RANGE);
  assign wr_div = wr_lane & prog_open & (avs_address == plc_pkg::ADDR_REF_DIV);
  assign rd_any = access & avs_read;
  assign rd_ctrl = rd_any & (avs_address == plc_pkg::ADDR_CTRL);
  assign range_zero = (range_reg == 8'h00);
  // a select that is set, or being set, pins the loop on
  assign pwr_clear_ok = ~bcs_reg & ~avs_writedata[plc_pkg::CTRL_BCS_BIT];
  // select may only rise with the loop on and a range programmed
  assign bcs_set_ok = pwr_on_reg & ~range_zero & ~stopping;
  assign lock_vis = auto_reg & lock_in;
  assign lock_change = auto_reg & (lock_in != lock_q_reg);
  assign stopping = (mode_reg == plc_pkg::PLC_STOP);
  // stop with the oscillator option clear darkens every output
  assign stop_dark = stopping & ~oscillator_stop_enable;
  assign hold_idle = (hold_cnt_reg == 3'h0);
  assign hold_last = (hold_cnt_reg == 3'h1);

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~access;
    end
  end

  // Mode tracking; wait does nothing to the clock state
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= plc_pkg::PLC_RUN;
    end else begin
      unique case (mode_reg)
        plc_pkg::PLC_RUN: begin
          if (stop_req) begin
            mode_reg <= plc_pkg::PLC_STOP;
          end else if (wait_req) begin
            mode_reg <= plc_pkg::PLC_WAIT;
          end
        end
        plc_pkg::PLC_WAIT: begin
          if (stop_req) begin
            mode_reg <= plc_pkg::PLC_STOP;
          end else if (!wait_req) begin
            mode_reg <= plc_pkg::PLC_RUN;
          end
        end
        plc_pkg::PLC_STOP: begin
          if (!stop_req) begin
            mode_reg <= plc_pkg::PLC_RUN;
          end
        end
        // Unused code falls back to run
        default: begin
          mode_reg <= plc_pkg::PLC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_q_reg <= 1'b0;
    end else begin
      lock_q_reg <= lock_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_reg <= 1'b0;
    end else if (wr_bw) begin
      auto_reg <= avs_writedata[plc_pkg::BW_AUTO_BIT];
    end
  end

  // enable forced clear in manual mode
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_reg <= 1'b0;
    end else if (!auto_reg) begin
      irq_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_reg <= avs_writedata[plc_pkg::CTRL_IRQ_EN_BIT];
    end
  end

  // control read clears, set wins over clear
  // no clear in break unless break_clear_enable is set
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_flag_reg <= 1'b0;
    end else if (lock_change) begin
      irq_flag_reg <= 1'b1;
    end else if (rd_ctrl && (!break_state || break_clear_enable)) begin
      irq_flag_reg <= 1'b0;
    end
  end

  // power cannot drop while select is set
  // loop also off in stop with oscillator running
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_on_reg <= 1'b1;
    end else if (wr_ctrl && (avs_writedata[plc_pkg::CTRL_PWR_ON_BIT] || pwr_clear_ok)) begin
      pwr_on_reg <= avs_writedata[plc_pkg::CTRL_PWR_ON_BIT];
    end
  end

  // select refused while range is zero
  always_ff @(posedge clk) begin
    if (rst) begin
      bcs_reg <= 1'b0;
    end else if (stopping || range_zero) begin
      bcs_reg <= 1'b0;
    end else if (wr_ctrl && (bcs_set_ok || !avs_writedata[plc_pkg::CTRL_BCS_BIT])) begin
      bcs_reg <= avs_writedata[plc_pkg::CTRL_BCS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mul_reg <= plc_pkg::MUL_RESET;
    end else if (wr_mul_hi) begin
      mul_reg[11:8] <= avs_writedata[3:0];
    end else if (wr_mul_lo) begin
      mul_reg[7:0] <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      range_reg <= plc_pkg::VCO_RANGE_RESET;
    end else if (wr_range) begin
      range_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= plc_pkg::REF_DIV_RESET;
    end else if (wr_div) begin
      div_reg <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mult_eff <= plc_pkg::MUL_RESET;
    end else begin
      mult_eff <= (mul_reg == 12'h000) ? plc_pkg::MUL_ONE : mul_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vco_range_eff <= plc_pkg::VCO_RANGE_RESET;
    end else begin
      vco_range_eff <= range_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_div_eff <= plc_pkg::REF_DIV_RESET;
    end else begin
      ref_div_eff <= (div_reg == 4'h0) ? plc_pkg::REF_DIV_ONE : div_reg;
    end
  end

  // loop off in stop regardless of oscillator option
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_enable <= 1'b1;
    end else begin
      loop_enable <= pwr_on_reg && !range_zero && !stopping;
    end
  end

  // oscillator runs on in stop when the option allows
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_enable <= 1'b1;
    end else begin
      osc_enable <= !stop_dark;
    end
  end

  // outputs held low only when the oscillator stops too
  always_ff @(posedge clk) begin
    if (rst) begin
      outputs_low <= 1'b0;
    end else begin
      outputs_low <= stop_dark;
    end
  end

  // hold output static while switching source
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_cnt_reg <= 3'h0;
    end else if (bcs_reg != vco_select && hold_idle) begin
      hold_cnt_reg <= plc_pkg::SWITCH_HOLD_CYCLES;
    end else if (!hold_idle) begin
      hold_cnt_reg <= hold_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_hold <= 1'b0;
    end else if (bcs_reg != vco_select && hold_idle) begin
      clock_hold <= 1'b1;
    end else if (hold_last) begin
      clock_hold <= 1'b0;
    end
  end

  // Source swaps only at the end of the hold, so the output never sees a runt phase
  always_ff @(posedge clk) begin
    if (rst) begin
      vco_select <= 1'b0;
    end else if (hold_last) begin
      vco_select <= bcs_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clockgen_interrupt_output <= 1'b0;
    end else begin
      clockgen_interrupt_output <= auto_reg && irq_en_reg && irq_flag_reg && !stop_dark;
    end
  end

  // flag reads zero in manual mode
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (avs_address)
      plc_pkg::ADDR_CTRL: read_mux = {24'h00_0000, irq_en_reg, irq_flag_reg & auto_reg, pwr_on_reg, bcs_reg, 4'h0};
      plc_pkg::ADDR_BW: read_mux = {24'h00_0000, auto_reg, lock_vis, 6'h00};
      plc_pkg::ADDR_MUL_HI: read_mux = {28'h000_0000, mul_reg[11:8]};
      plc_pkg::ADDR_MUL_LO: read_mux = {24'h00_0000, mul_reg[7:0]};
      plc_pkg::ADDR_VCO_RANGE: read_mux = {24'h00_0000, range_reg};
      plc_pkg::ADDR_REF_DIV: read_mux = {28'h000_0000, div_reg};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // Read data is latched at the accepting edge and stands until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_any) begin
      avs_readdata <= read_mux;
    end
  end
endmodule : plc_core

//--- hdl/plc_pkg.sv
// Package for the loop programming and control block.
// Assumes a 25 MHz bus clock and a 32-bit Avalon-MM register port.
package plc_pkg;
  // Register byte addresses
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_BW = 5'h04;
  localparam logic [4:0] ADDR_MUL_HI = 5'h08;
  localparam logic [4:0] ADDR_MUL_LO = 5'h0c;
  localparam logic [4:0] ADDR_VCO_RANGE = 5'h10;
  localparam logic [4:0] ADDR_REF_DIV = 5'h14;
  // Control register fields
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam int CTRL_IRQ_FLAG_BIT = 6;
  localparam int CTRL_PWR_ON_BIT = 5;
  localparam int CTRL_BCS_BIT = 4;
  // Bandwidth register fields
  localparam int BW_AUTO_BIT = 7;
  localparam int BW_LOCK_BIT = 6;
  // Reset values, and the values that stand in for a zero setting
  localparam logic [11:0] MUL_RESET = 12'h040;
  localparam logic [11:0] MUL_ONE = 12'h001;
  localparam logic [7:0] VCO_RANGE_RESET = 8'h40;
  localparam logic [3:0] REF_DIV_RESET = 4'h1;
  localparam logic [3:0] REF_DIV_ONE = 4'h1;
  // Switch-over hold: six cycles of the bus clock
  localparam logic [2:0] SWITCH_HOLD_CYCLES = 3'h6;
  typedef enum logic [1:0] {PLC_RUN, PLC_WAIT, PLC_STOP} plc_mode_t;
endpackage : plc_pkg

//--- test/plc_core_asserts.sv
// Assertions on the ports of plc_core.
// Assumes clk is the only clock and rst is synchronous.
`timescale 1ns/1ps
module plc_core_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_write,
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic oscillator_stop_enable,
  input wire logic loop_enable,
  input wire logic clock_hold,
  input wire logic osc_enable,
  input wire logic outputs_low,
  input wire logic clockgen_interrupt_output,
  input wire logic [11:0] mult_eff,
  input wire logic [7:0] vco_range_eff,
  input wire logic [3:0] ref_div_eff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_mult_never_zero: assert property (mult_eff != 12'h000) else $error("multiplier zero");
  a_div_never_zero: assert property (ref_div_eff != 4'h0) else $error("divider zero");
  a_range_zero_off: assert property (vco_range_eff == 8'h00 |-> !loop_enable) else $error("loop on");
  a_stop_all_low: assert property ((stop_req && !oscillator_stop_enable)[*3] |->
    outputs_low && !osc_enable && !clockgen_interrupt_output) else $error("stop outputs");
  a_stop_osc_kept: assert property ((stop_req && oscillator_stop_enable)[*3] |-> osc_enable)
    else $error("osc stopped");
  a_stop_loop_off: assert property (stop_req[*3] |-> !loop_enable) else $error("loop on in stop");
  a_hold_six_cycles: assert property ($rose(clock_hold) |-> clock_hold[*6] ##1 !clock_hold)
    else $error("hold length");
  a_wait_keeps_state: assert property (wait_req && !avs_write |=>
    $stable(loop_enable) && $stable(mult_eff) && $stable(vco_range_eff)) else $error("wait changed state");
endmodule : plc_core_asserts

bind plc_core plc_core_asserts u_chk (.clk, .rst, .avs_write, .stop_req, .wait_req, .oscillator_stop_enable,
  .loop_enable, .clock_hold, .osc_enable, .outputs_low, .clockgen_interrupt_output, .mult_eff,
  .vco_range_eff, .ref_div_eff);

//--- test/plc_core_tb.sv
// Self-checking bench for plc_core; the register model lives in bench variables.
// Assumes each bus request is answered within 50 cycles.
`timescale 1ns/1ps
module plc_core_tb;
  logic clk, rst, avs_read, avs_write, lock_in, stop_req, wait_req, brk, bce, ose;
  logic avs_waitrequest, loop_enable, vco_select, clock_hold, osc_enable, outputs_low, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [11:0] mult_eff;
  logic [7:0] vco_range_eff, d;
  logic [3:0] ref_div_eff;
  int error_cnt, tests_run, i;
  bit pw, base_clock_select, ie, am, flag;
  bit [7:0] mhi, mlo, rng, div;
  plc_core u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .lock_in, .stop_req, .wait_req, .break_state(brk),
    .break_clear_enable(bce), .oscillator_stop_enable(ose), .loop_enable, .vco_select, .clock_hold,
    .osc_enable, .outputs_low, .clockgen_interrupt_output(irq), .mult_eff, .vco_range_eff, .ref_div_eff);
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] dd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, dd};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      summarize();
    end
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] dd);
    bit b;
    bus(a, 1'b1, dd);
    b = base_clock_select;
    case (a)
      plc_pkg::ADDR_CTRL: begin
        ie = dd[7] && am;
        base_clock_select = dd[4] && (base_clock_select || (pw && rng != 0));
        if (dd[5] || (!b && !dd[4])) pw = dd[5];
      end
      plc_pkg::ADDR_BW: begin
        am = dd[7];
        ie = ie && am;
      end
      // Locked fields keep their old value while the loop is on
      plc_pkg::ADDR_MUL_HI: if (!pw) mhi = dd & 8'h0f;
      plc_pkg::ADDR_MUL_LO: if (!pw) mlo = dd;
      plc_pkg::ADDR_VCO_RANGE: if (!pw) rng = dd;
      plc_pkg::ADDR_REF_DIV: if (!pw) div = dd & 8'h0f;
      default: ;
    endcase
  endtask : wr
  task automatic rd(input logic [4:0] a);
    logic [7:0] e;
    case (a)
      plc_pkg::ADDR_CTRL: e = {ie, flag && am, pw, base_clock_select, 4'h0};
      plc_pkg::ADDR_BW: e = {am, lock_in && am, 6'h00};
      plc_pkg::ADDR_MUL_HI: e = mhi;
      plc_pkg::ADDR_MUL_LO: e = mlo;
      plc_pkg::ADDR_VCO_RANGE: e = rng;
      plc_pkg::ADDR_REF_DIV: e = div;
      default: e = 8'h00;
    endcase
    bus(a, 1'b0, 8'h00);
    chk(q, {24'h000000, e});
    if (a == plc_pkg::ADDR_CTRL && !(brk && !bce)) flag = 1'b0;
  endtask : rd
  task automatic dump();
    for (int k = 0; k < 7; k++) rd(5'(k * 4));
  endtask : dump
  task automatic eff();
    repeat (8) @(posedge clk);
    chk(mult_eff, ({mhi[3:0], mlo} == 12'h000) ? 12'h001 : {mhi[3:0], mlo});
    chk(ref_div_eff, (div == 8'h00) ? 4'h1 : div[3:0]);
    chk(vco_range_eff, rng);
    chk(loop_enable, pw && rng != 8'h00);
    chk(vco_select, base_clock_select);
    chk(clock_hold, 1'b0);
  endtask : eff
  task automatic tog();
    lock_in <= !lock_in;
    repeat (4) @(posedge clk);
    flag = flag || am;
    chk(irq, ie && flag);
  endtask : tog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, lock_in, stop_req, wait_req, brk, bce, ose} = 8'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    {pw, base_clock_select, ie, am, flag} = 5'h10;
    {mhi, mlo, rng, div} = 32'h00404001;
    error_cnt = 0;
    tests_run = 0;
    i = $urandom(32'h28f8d790);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    eff();
    dump();
    wr(5'h0c, 8'h55);
    wr(5'h10, 8'h00);
    wr(5'h14, 8'h07);
    dump();
    wr(5'h00, 8'h10);
    wr(5'h00, 8'h00);
    rd(5'h00);
    wr(5'h00, 8'h00);
    wr(5'h00, 8'h10);
    rd(5'h00);
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(5'h08, i[0] ? ~d : 8'hf0);
      wr(5'h0c, i[0] ? d : 8'h00);
      wr(5'h14, i[0] ? d : 8'hf0);
      dump();
      eff();
    end
    wr(5'h10, 8'h00);
    wr(5'h00, 8'h20);
    wr(5'h00, 8'h30);
    rd(5'h00);
    eff();
    wr(5'h00, 8'h00);
    wr(5'h10, 8'h40);
    wr(5'h00, 8'h20);
    lock_in <= 1'b1;
    wr(5'h00, 8'h30);
    chk(clock_hold, 1'b1);
    eff();
    wr(5'h04, 8'h80);
    wr(5'h00, 8'hb0);
    tog();
    rd(5'h04);
    rd(5'h00);
    rd(5'h00);
    wr(5'h00, 8'h30);
    tog();
    brk <= 1'b1;
    rd(5'h00);
    rd(5'h00);
    bce <= 1'b1;
    rd(5'h00);
    brk <= 1'b0;
    rd(5'h00);
    wr(5'h04, 8'h00);
    wr(5'h00, 8'hb0);
    tog();
    rd(5'h00);
    wait_req <= 1'b1;
    repeat (10) @(posedge clk);
    wait_req <= 1'b0;
    eff();
    for (i = 0; i < 2; i++) begin
      ose <= i[0];
      stop_req <= 1'b1;
      base_clock_select = 1'b0;
      repeat (10) @(posedge clk);
      chk(osc_enable, i[0]);
      chk(outputs_low, !i[0]);
      stop_req <= 1'b0;
      repeat (3) @(posedge clk);
      rd(5'h00);
      wr(5'h00, 8'h30);
    end
    eff();
    summarize();
  end
endmodule : plc_core_tb
